// ===== hdl/sfph_pkg.sv
package sfph_pkg;

  // ----------------------------------------
  // Array organisation
  // ----------------------------------------
  localparam int ARRAY_BYTES = 524288;
  localparam int PAGE_BYTES = 256;
  localparam int PAGE_COUNT = 2048;
  localparam int SECTOR_COUNT = 8;
  localparam int ADDR_W = 24;
  localparam int SECTOR_LSB = 16;
  localparam int PAGE_LSB = 8;
  localparam int PAGE_W = 11;
  localparam int SECTOR_IDX_W = 8;

  // ----------------------------------------
  // Reset values and decode constants
  // ----------------------------------------
  localparam logic [2:0] GUARD_RESET = 3'h0;
  localparam logic LOCK_RESET = 1'b0;
  localparam logic [7:0] FIRST_NONE = 8'hFF;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [1:0] {
    SFPH_D32 = 2'h0,
    SFPH_D64 = 2'h1,
    SFPH_D128 = 2'h2
  } sfph_density_t;

  typedef enum logic [1:0] {
    SFPH_OP_PROG = 2'h0,
    SFPH_OP_SERASE = 2'h1,
    SFPH_OP_BERASE = 2'h2,
    SFPH_OP_SWRITE = 2'h3
  } sfph_op_t;

  typedef enum logic [1:0] {
    SFPH_IDLE = 2'h0,
    SFPH_ACTIVE = 2'h1,
    SFPH_PAUSED = 2'h3
  } sfph_link_t;

  // Lowest protected sector index, FIRST_NONE when nothing is protected
  function automatic logic [7:0] sfph_first_protected(input logic [1:0] dens, input logic [2:0] bp);
    logic [7:0] f;
    f = 8'h00;
    unique case (dens)
      SFPH_D32:
        unique case (bp)
          3'h0: f = FIRST_NONE;
          3'h1: f = 8'h1F;
          3'h2: f = 8'h1E;
          3'h3: f = 8'h1C;
          3'h4: f = 8'h18;
          3'h5: f = 8'h10;
          default: f = 8'h00;
        endcase
      SFPH_D64:
        unique case (bp)
          3'h0: f = FIRST_NONE;
          3'h1: f = 8'h3F;
          3'h2: f = 8'h3E;
          3'h3: f = 8'h3C;
          3'h4: f = 8'h38;
          3'h5: f = 8'h30;
          3'h6: f = 8'h20;
          3'h7: f = 8'h00;
        endcase
      SFPH_D128:
        unique case (bp)
          3'h0: f = FIRST_NONE;
          3'h1: f = 8'h7E;
          3'h2: f = 8'h7C;
          3'h3: f = 8'h78;
          3'h4: f = 8'h70;
          3'h5: f = 8'h60;
          3'h6: f = 8'h40;
          3'h7: f = 8'h00;
        endcase
      // Unknown density: fail safe, everything protected
      default: f = 8'h00;
    endcase
    return f;
  endfunction

endpackage

// ===== hdl/sfph_protect_hold.sv
// Operation
// - 32-sector guard decode: none to all
// - 64-sector guard decode: none to all
// - 128-sector guard decode: none to all
// - Bulk erase only with guard bits zero
// - Pause never aborts a running cycle
// - Pause starts at pause low, clock low
// - Pause ends at pause high, clock low
// - Paused: output off, clock/data ignored
// - Deselect during pause resets serial logic
// - Program pages; erase sector or bulk only
// - 512K bytes, 8 sectors, 2048 pages
// - Write guard freezes status bits
// - Modifying requests need write latch set
`timescale 1ns/10ps
`default_nettype none

module sfph_protect_hold (
  input wire logic clk,
  input wire logic nrst,
  input wire logic select_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic pause_n,
  input wire logic write_guard_n,
  input wire logic [1:0] density_sel,
  input wire logic [7:0] tx_byte,
  input wire logic cmd_write_enable,
  input wire logic cmd_write_disable,
  input wire logic cmd_status_write,
  input wire logic [3:0] status_wdata,
  input wire logic cmd_page_program,
  input wire logic cmd_sector_erase,
  input wire logic cmd_bulk_erase,
  input wire logic [23:0] cmd_addr,
  input wire logic op_done,
  output logic serial_out,
  output logic serial_out_oe_n,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic link_paused,
  output logic guard_bit_0,
  output logic guard_bit_1,
  output logic guard_bit_2,
  output logic status_lock,
  output logic write_latch,
  output logic busy,
  output logic op_start,
  output logic [1:0] op_kind,
  output logic [23:0] op_addr,
  output logic [10:0] op_page,
  output logic op_refused
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] sel_p;
    logic [1:0] sck_p;
    logic [1:0] din_p;
    logic [1:0] pause_p;
    logic [1:0] wg_p;
    logic sck_d;
    sfph_pkg::sfph_link_t link;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] rx;
    logic rx_valid;
    logic out_bit;
    logic [2:0] guard;
    logic lock;
    logic latch;
    logic busy;
    logic start;
    logic refused;
    logic [1:0] kind;
    logic [23:0] addr;
  } sfph_state_t;

  sfph_state_t st_reg;
  sfph_state_t st_next;
  logic sel_s;
  logic sck_s;
  logic pause_s;
  logic wg_s;
  logic [7:0] first_prot;
  logic sect_prot;

  assign sel_s = st_reg.sel_p[1];
  assign sck_s = st_reg.sck_p[1];
  assign pause_s = st_reg.pause_p[1];
  assign wg_s = st_reg.wg_p[1];
  assign first_prot = sfph_pkg::sfph_first_protected(density_sel, st_reg.guard);
  // Sectors are 64 KB; index taken from the upper address byte
  assign sect_prot = (first_prot != sfph_pkg::FIRST_NONE)
    && (cmd_addr[23:sfph_pkg::SECTOR_LSB] >= first_prot);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.sel_p = {st_reg.sel_p[0], select_n};
    st_next.sck_p = {st_reg.sck_p[0], serial_clk};
    st_next.din_p = {st_reg.din_p[0], serial_in};
    st_next.pause_p = {st_reg.pause_p[0], pause_n};
    st_next.wg_p = {st_reg.wg_p[0], write_guard_n};
    st_next.sck_d = sck_s;
    st_next.rx_valid = 1'b0;
    st_next.start = 1'b0;
    st_next.refused = 1'b0;

    // Link side; pause is level-checked so a late clock low still enters/leaves
    unique case (st_reg.link)
      sfph_pkg::SFPH_IDLE:
      begin
        st_next.bit_cnt = 3'h0;
        if (!sel_s)
          st_next.link = sfph_pkg::SFPH_ACTIVE;
      end
      sfph_pkg::SFPH_ACTIVE:
      begin
        if (sel_s)
          st_next.link = sfph_pkg::SFPH_IDLE;
        else if (!pause_s && !sck_s)
          st_next.link = sfph_pkg::SFPH_PAUSED;
        else if (sck_s && !st_reg.sck_d)
        begin
          st_next.shift = {st_reg.shift[6:0], st_reg.din_p[1]};
          st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
          if (st_reg.bit_cnt == sfph_pkg::BIT_LAST)
          begin
            st_next.rx = {st_reg.shift[6:0], st_reg.din_p[1]};
            st_next.rx_valid = 1'b1;
          end
        end
        else if (!sck_s && st_reg.sck_d)
          st_next.out_bit = tx_byte[3'h7 - st_reg.bit_cnt];
      end
      sfph_pkg::SFPH_PAUSED:
      begin
        // Clock and data ignored here, shift position kept
        if (sel_s)
        begin
          st_next.link = sfph_pkg::SFPH_IDLE;
          st_next.bit_cnt = 3'h0;
          st_next.shift = 8'h00;
        end
        else if (pause_s && !sck_s)
          st_next.link = sfph_pkg::SFPH_ACTIVE;
      end
      default: st_next.link = sfph_pkg::SFPH_IDLE;
    endcase

    // Internal cycle runs independent of the link state
    if (op_done)
    begin
      st_next.busy = 1'b0;
      st_next.latch = 1'b0;
    end
    if (cmd_write_disable)
      st_next.latch = 1'b0;
    if (cmd_write_enable)
      st_next.latch = 1'b1;

    // Only erase kinds are sector and bulk; no page erase exists
    if (cmd_status_write || cmd_page_program || cmd_sector_erase || cmd_bulk_erase)
    begin
      st_next.refused = 1'b1;
      st_next.addr = cmd_addr;
      if (st_reg.latch && !st_reg.busy)
      begin
        if (cmd_status_write && wg_s)
        begin
          st_next.guard = status_wdata[2:0];
          st_next.lock = status_wdata[3];
          st_next.kind = sfph_pkg::SFPH_OP_SWRITE;
          st_next.refused = 1'b0;
        end
        else if (cmd_page_program && !sect_prot)
        begin
          st_next.kind = sfph_pkg::SFPH_OP_PROG;
          st_next.refused = 1'b0;
        end
        else if (cmd_sector_erase && !sect_prot)
        begin
          st_next.kind = sfph_pkg::SFPH_OP_SERASE;
          st_next.refused = 1'b0;
        end
        else if (cmd_bulk_erase && st_reg.guard == 3'h0)
        begin
          st_next.kind = sfph_pkg::SFPH_OP_BERASE;
          st_next.refused = 1'b0;
        end
      end
      st_next.start = !st_next.refused;
      st_next.busy = st_reg.busy || !st_next.refused;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg <= '0;
      st_reg.sel_p <= 2'h3;
      st_reg.pause_p <= 2'h3;
      st_reg.wg_p <= 2'h3;
      st_reg.link <= sfph_pkg::SFPH_IDLE;
      st_reg.guard <= sfph_pkg::GUARD_RESET;
      st_reg.lock <= sfph_pkg::LOCK_RESET;
    end
    else
      st_reg <= st_next;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign serial_out = st_reg.out_bit;
  assign serial_out_oe_n = (st_reg.link != sfph_pkg::SFPH_ACTIVE);
  assign rx_byte = st_reg.rx;
  assign rx_valid = st_reg.rx_valid;
  assign link_paused = (st_reg.link == sfph_pkg::SFPH_PAUSED);
  assign guard_bit_0 = st_reg.guard[0];
  assign guard_bit_1 = st_reg.guard[1];
  assign guard_bit_2 = st_reg.guard[2];
  assign status_lock = st_reg.lock;
  assign write_latch = st_reg.latch;
  assign busy = st_reg.busy;
  assign op_start = st_reg.start;
  assign op_kind = st_reg.kind;
  assign op_addr = st_reg.addr;
  assign op_page = st_reg.addr[sfph_pkg::PAGE_LSB +: sfph_pkg::PAGE_W];
  assign op_refused = st_reg.refused;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_bulk_gate: assert property (cmd_bulk_erase && !cmd_status_write && !cmd_page_program && !cmd_sector_erase
    && st_reg.guard != 3'h0 |=> op_refused && !op_start) else $error("bulk erase accepted while guarded");
  a_busy_keeps: assert property (busy && !op_done |=> busy) else $error("busy dropped without done");
  a_pause_entry: assert property (st_reg.link == sfph_pkg::SFPH_ACTIVE && !sel_s && !pause_s && !sck_s
    |=> link_paused) else $error("pause not entered");
  a_pause_exit: assert property (link_paused && !sel_s && pause_s && !sck_s
    |=> st_reg.link == sfph_pkg::SFPH_ACTIVE) else $error("pause not left");
  a_pause_quiet: assert property (link_paused |-> serial_out_oe_n ##1 (!link_paused
    || $stable(st_reg.bit_cnt))) else $error("paused link not quiet");
  a_pause_deselect: assert property (link_paused && sel_s |=> st_reg.link == sfph_pkg::SFPH_IDLE
    && st_reg.bit_cnt == 3'h0) else $error("deselect in pause kept state");
  a_guard_freeze: assert property (!wg_s |=> $stable(st_reg.guard) && $stable(status_lock))
    else $error("status changed under write guard");
  a_latch_needed: assert property (op_start |-> $past(st_reg.latch)) else $error("op without latch");
  a_prot_skip: assert property ((cmd_page_program || cmd_sector_erase) && !cmd_status_write && sect_prot
    |=> !op_start) else $error("protected sector modified");
  a_decode_d32: assert property (density_sel == sfph_pkg::SFPH_D32 && st_reg.guard == 3'h5
    |-> first_prot == 8'h10) else $error("32-sector decode wrong");
  a_decode_d64: assert property (density_sel == sfph_pkg::SFPH_D64 && st_reg.guard == 3'h3
    |-> first_prot == 8'h3C) else $error("64-sector decode wrong");
  a_decode_d128: assert property (density_sel == sfph_pkg::SFPH_D128 && st_reg.guard == 3'h1
    |-> first_prot == 8'h7E) else $error("128-sector decode wrong");

  c_pause_round: cover property (link_paused ##1 st_reg.link == sfph_pkg::SFPH_ACTIVE);
  c_pause_drop: cover property (link_paused && sel_s);
  c_bulk_ok: cover property (op_start && op_kind == sfph_pkg::SFPH_OP_BERASE);
  c_prog_refused: cover property (op_refused && sect_prot);

endmodule

`default_nettype wire

// ===== verif/sfph_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// --------
// Host serial controller
// --------
module sfph_host_model (
  output logic select_n,
  output logic serial_clk,
  output logic serial_in,
  output logic pause_n
);
  initial
  begin
    select_n = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
    pause_n = 1'b1;
  end
  // Clock stands low between bits and frames
  task automatic bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--)
    begin
      serial_in = b[i];
      #62.5 serial_clk = 1'b1;
      #62.5 serial_clk = 1'b0;
    end
    serial_in = ~serial_in;
  endtask
  task automatic clk(input logic v);
    #50 serial_clk = v;
    #100;
  endtask
  // Pause is driven whatever select does; t_desel releases it while deselected
  task automatic pause(input logic v);
    #100 pause_n = v;
    #100;
  endtask
  task automatic sel(input logic v);
    #100 select_n = v;
    if (v)
      serial_in = ~serial_in;
    #100;
  endtask
endmodule
`default_nettype wire

// ===== verif/test_sfph_protect_hold.sv
`timescale 1ns/10ps
`default_nettype none
module test_sfph_protect_hold;
  logic clk = 1'b0, nrst = 1'b0, write_guard_n, op_done;
  logic cmd_write_enable, cmd_write_disable, cmd_status_write;
  logic cmd_page_program, cmd_sector_erase, cmd_bulk_erase;
  logic [1:0] density_sel;
  logic [7:0] tx_byte;
  logic [3:0] status_wdata;
  logic [23:0] cmd_addr;
  wire logic select_n, serial_clk, serial_in, pause_n;
  logic serial_out, serial_out_oe_n, rx_valid, link_paused, guard_bit_0, guard_bit_1, guard_bit_2;
  logic status_lock, write_latch, busy, op_start, op_refused;
  logic [7:0] rx_byte;
  logic [1:0] op_kind;
  logic [23:0] op_addr;
  logic [10:0] op_page;
  int fail_count = 0, n_compared = 0, nrx = 0;

  sfph_protect_hold i_sfph_protect_hold (.*);
  sfph_host_model i_sfph_host_model (.*);

  always #5 clk = ~clk;
  always @(posedge clk) if (rx_valid === 1'b1) nrx++;

  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic done();
    op_done = 1'b1;
    cyc(1);
    op_done = 1'b0;
    chk(busy === 1'b0 && write_latch === 1'b0, "done clears");
  endtask
  // Write enable, then one request; fin=0 leaves the cycle running
  task automatic req(input int k, input logic [23:0] a, input logic ok, input logic fin);
    cyc(1);
    cmd_write_enable = 1'b1;
    cyc(1);
    cmd_write_enable = 1'b0;
    cmd_addr = a;
    status_wdata = a[3:0];
    {cmd_page_program, cmd_sector_erase, cmd_bulk_erase, cmd_status_write} = {k == 0, k == 1, k == 2, k == 3};
    cyc(1);
    {cmd_page_program, cmd_sector_erase, cmd_bulk_erase, cmd_status_write} = 4'h0;
    chk(op_start === ok && op_refused === !ok, "request outcome");
    if (ok)
      chk(busy === 1'b1 && op_kind === 2'(k) && op_addr === a && op_page === a[18:8], "fields");
    if (ok && fin)
      done();
  endtask

  task automatic t_decode();
    int s, c, f;
    for (int d = 0; d < 3; d++)
      for (int bp = 0; bp < 8; bp++)
      begin
        density_sel = 2'(d);
        s = 32 << d;
        c = (bp == 0) ? 0 : 1 << (bp - 1 + (d == 2));
        f = s - ((c > s) ? s : c);
        req(3, 24'(bp), 1'b1, 1'b1);
        chk({guard_bit_2, guard_bit_1, guard_bit_0} === 3'(bp), "guard bits");
        if (f < s)
          req(1, 24'(f) << 16, 1'b0, 1'b1);
        if (f > 0)
          req(1, 24'(f - 1) << 16 | 24'h00FFFF, 1'b1, 1'b1);
        req(2, 24'h0, bp == 0, 1'b1);
      end
  endtask
  task automatic t_guard();
    req(3, 24'h0, 1'b1, 1'b1);
    write_guard_n = 1'b0;
    req(3, 24'h5, 1'b0, 1'b1);
    chk({guard_bit_2, guard_bit_1, guard_bit_0} === 3'h0, "frozen guard");
    write_guard_n = 1'b1;
    cyc(4);
  endtask
  task automatic t_latch();
    cmd_write_disable = 1'b1;
    cyc(1);
    cmd_write_disable = 1'b0;
    cmd_page_program = 1'b1;
    cyc(1);
    cmd_page_program = 1'b0;
    chk(op_refused === 1'b1 && op_start === 1'b0 && write_latch === 1'b0, "no latch");
  endtask
  task automatic t_pause();
    nrx = 0;
    i_sfph_host_model.sel(1'b0);
    req(0, 24'h012345, 1'b1, 1'b0);
    i_sfph_host_model.bits(8'hC3, 4);
    i_sfph_host_model.pause(1'b0);
    chk(link_paused === 1'b1 && serial_out_oe_n === 1'b1 && busy === 1'b1, "paused");
    i_sfph_host_model.bits(8'h0F, 3);
    i_sfph_host_model.clk(1'b1);
    i_sfph_host_model.pause(1'b1);
    chk(link_paused === 1'b1, "exit waits");
    i_sfph_host_model.clk(1'b0);
    chk(link_paused === 1'b0 && serial_out_oe_n === 1'b0, "resumed");
    i_sfph_host_model.bits(8'h30, 4);
    cyc(5);
    chk(rx_byte === 8'hC3 && nrx == 1, "byte kept");
    done();
    i_sfph_host_model.sel(1'b1);
  endtask
  task automatic t_desel();
    nrx = 0;
    i_sfph_host_model.sel(1'b0);
    i_sfph_host_model.bits(8'hFF, 3);
    i_sfph_host_model.pause(1'b0);
    i_sfph_host_model.sel(1'b1);
    cyc(4);
    chk(link_paused === 1'b0 && serial_out_oe_n === 1'b1, "link reset");
    i_sfph_host_model.pause(1'b1);
    i_sfph_host_model.sel(1'b0);
    i_sfph_host_model.bits(8'h5A, 8);
    cyc(5);
    chk(rx_byte === 8'h5A && nrx == 1, "partial dropped");
    chk(serial_out === tx_byte[7], "output bit");
    i_sfph_host_model.sel(1'b1);
  endtask

  task automatic results();
    $display("Compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    write_guard_n = 1'b1;
    op_done = 1'b0;
    cmd_write_enable = 1'b0;
    cmd_write_disable = 1'b0;
    cmd_status_write = 1'b0;
    cmd_page_program = 1'b0;
    cmd_sector_erase = 1'b0;
    cmd_bulk_erase = 1'b0;
    density_sel = 2'h0;
    tx_byte = 8'hA5;
    status_wdata = 4'h0;
    cmd_addr = 24'h000000;
    cyc(3);
    nrst = 1'b1;
    chk(busy === 1'b0 && write_latch === 1'b0 && serial_out_oe_n === 1'b1, "reset");
    t_decode();
    t_guard();
    t_latch();
    t_pause();
    t_desel();
    results();
  end
  // Whole run needs under ten microseconds
  initial
  begin
    #200000;
    fail_count++;
    results();
  end
endmodule
`default_nettype wire
